// ===== wwd_pkg.sv
/*
 * wwd_pkg: constants for the windowed watchdog block.
 * assumes: apb register bus with 32-bit data, byte addresses, 20 MHz core clock.
 */
`default_nettype none
package wwd_pkg;
    // register byte offsets
    localparam logic [7:0] WWD_OFS_CTRL    = 8'h00;
    localparam logic [7:0] WWD_OFS_RELOAD  = 8'h04;
    localparam logic [7:0] WWD_OFS_FEED    = 8'h08;
    localparam logic [7:0] WWD_OFS_COUNT   = 8'h0C;
    localparam logic [7:0] WWD_OFS_WARN    = 8'h10;
    localparam logic [7:0] WWD_OFS_WINDOW  = 8'h14;
    localparam logic [7:0] WWD_OFS_STATUS  = 8'h18;
    localparam logic [7:0] WWD_OFS_IRQ_EN  = 8'h1C;
    localparam logic [7:0] WWD_OFS_IRQ_CLR = 8'h20;
    // control field positions
    localparam int WWD_CTL_ENABLE  = 0;
    localparam int WWD_CTL_RESET   = 1;
    localparam int WWD_CTL_PROTECT = 2;
    localparam int WWD_CTL_SLEEP   = 3;
    localparam int WWD_CTL_DEBUG   = 4;
    localparam int WWD_CTL_BITS    = 5;
    // status field positions
    localparam int WWD_ST_TIMEOUT  = 0;
    localparam int WWD_ST_WARN     = 1;
    localparam int WWD_ST_BADFEED  = 2;
    localparam int WWD_ST_WDRESET  = 3;
    localparam int WWD_ST_BITS     = 4;
    // counter geometry and reset values
    localparam int          WWD_CNT_W       = 24;
    localparam logic [23:0] WWD_CNT_MIN     = 24'h000100;
    localparam logic [23:0] WWD_RELOAD_RST  = 24'hFFFFFF;
    localparam logic [23:0] WWD_WINDOW_RST  = 24'hFFFFFF;
    localparam logic [9:0]  WWD_WARN_RST    = 10'h000;
    localparam logic [1:0]  WWD_PRESCALE    = 2'h3;
    // feed keys
    localparam logic [7:0]  WWD_KEY_FIRST   = 8'hAA;
    localparam logic [7:0]  WWD_KEY_SECOND  = 8'h55;
endpackage
`default_nettype wire

// ===== wwd_sync.sv
/*
 * wwd_sync: two-flop synchroniser for one level.
 * assumes: input may change at any time relative to core_clk.
 */
`timescale 1ns/1ps
`default_nettype none
module wwd_sync (
    // clock and reset
    input  wire logic core_clk,
    input  wire logic rst,
    // level in and out
    input  wire logic async_in,
    output logic      sync_out
);
    logic meta_q;
    logic meta_d;
    logic sync_q;
    logic sync_d;

    // first flop only feeds the second
    always_comb begin
        meta_d = async_in;
        sync_d = meta_q;
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end

    assign sync_out = sync_q;
endmodule
`default_nettype wire

// ===== wwd_top.sv
/*
 * wwd_top: windowed watchdog with apb registers, warning and fault interrupts.
 * assumes: watchdog_clock is a slow pin clock, sampled here as an ordinary
 * input; sleep and debug-halt levels come from outside the core clock domain.
 */
// The register addresses and register access over APB were left to the implementer.
// How it works
// - when enabled, countdown expiry without feed asserts chip reset output.
// - reset-select bit clear turns the watchdog event into an interrupt instead.
// - with window below reload, a feed while count above window is a fault.
// - warning interrupt flags on the tick that moves count down from the warning value.
// - 24-bit counter decrements once per four watchdog clock edges.
// - reload values below 256 are raised to 256; steps of four clocks.
// - enable bit is set-only; only reset or watchdog reset clears it.
// - an incorrect feed sequence fires the watchdog event at once.
// - with protect set, reload writes are ignored until warning point reached.
// - a sticky flag records that the watchdog issued a reset.
// - sleep-run bit lets counting continue while deep sleep is active.
`timescale 1ns/1ps
`default_nettype none
module wwd_top
    import wwd_pkg::*;
(
    // clock and reset
    input  wire logic        core_clk,
    input  wire logic        rst,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // watchdog clock and power state pins
    input  wire logic        watchdog_clock,
    input  wire logic        deep_sleep,
    input  wire logic        debug_halt,
    // results
    output logic             wdt_reset_req,
    output logic             irq
);
    // synchronised pin levels
    logic wclk_s;
    logic sleep_s;
    logic halt_s;

    wwd_sync u_sync_clk (
        .core_clk (core_clk),
        .rst      (rst),
        .async_in (watchdog_clock),
        .sync_out (wclk_s)
    );
    wwd_sync u_sync_sleep (
        .core_clk (core_clk),
        .rst      (rst),
        .async_in (deep_sleep),
        .sync_out (sleep_s)
    );
    wwd_sync u_sync_halt (
        .core_clk (core_clk),
        .rst      (rst),
        .async_in (debug_halt),
        .sync_out (halt_s)
    );

    // state
    logic [WWD_CTL_BITS-1:0] ctrl_q,   ctrl_d;
    logic [WWD_CNT_W-1:0]    reload_q, reload_d;
    logic [WWD_CNT_W-1:0]    cnt_q,    cnt_d;
    logic [WWD_CNT_W-1:0]    window_q, window_d;
    logic [9:0]              warn_q,   warn_d;
    logic [WWD_ST_BITS-1:0]  stat_q,   stat_d;
    logic [WWD_ST_BITS-1:0]  ien_q,    ien_d;
    logic [1:0]              pre_q,    pre_d;
    logic                    wclk_q,   wclk_d;
    logic                    armed_q,  armed_d;
    logic                    rreq_q,   rreq_d;
    logic [31:0]             rdata_q,  rdata_d;
    logic                    warned_q, warned_d;

    // decoded bus strobes and watchdog events
    logic wr_stb;
    logic rd_stb;
    logic tick;
    logic feed_ok;
    logic feed_bad;
    logic expire;
    logic event_fire;
    logic run;
    logic mapped;

    // no wait states: pready always high; read data is latched in the
    // setup cycle so that it stands from a flop through the access cycle
    assign pready  = 1'b1;
    assign wr_stb  = psel && penable && pwrite;
    assign rd_stb  = psel && !penable && !pwrite;
    assign pslverr = psel && penable && !mapped;
    assign prdata  = rdata_q;

    // address decode; unmapped offsets answer with pslverr
    always_comb begin
        unique case (paddr)
            WWD_OFS_CTRL, WWD_OFS_RELOAD, WWD_OFS_FEED, WWD_OFS_COUNT,
            WWD_OFS_WARN, WWD_OFS_WINDOW, WWD_OFS_STATUS, WWD_OFS_IRQ_EN,
            WWD_OFS_IRQ_CLR: mapped = 1'b1;
            default:         mapped = 1'b0;
        endcase
    end

    // counter advances when enabled, not halted while the debug bit is set, not sleeping unless allowed
    assign run = ctrl_q[WWD_CTL_ENABLE]
               && !(halt_s && ctrl_q[WWD_CTL_DEBUG])
               && !(sleep_s && !ctrl_q[WWD_CTL_SLEEP]);
    // one tick per four rising watchdog clock edges
    assign tick = run && wclk_s && !wclk_q && (pre_q == WWD_PRESCALE);

    // feed decode: second key right after first key, any other access breaks it
    // faults only count while enabled; feeds while disabled just load
    assign feed_ok  = wr_stb && paddr == WWD_OFS_FEED && armed_q
                    && pwdata[7:0] == WWD_KEY_SECOND;
    assign feed_bad = ctrl_q[WWD_CTL_ENABLE] && psel && penable && (
                      (armed_q && !feed_ok)
                    || (wr_stb && paddr == WWD_OFS_FEED && !armed_q
                        && pwdata[7:0] != WWD_KEY_FIRST)
                    || (feed_ok && cnt_q > window_q));
    // expiry is seen only on a tick, so the zero count lasts one full tick
    assign expire     = tick && cnt_q == '0;
    assign event_fire = expire || feed_bad;

    // register and counter next state
    always_comb begin
        ctrl_d   = ctrl_q;
        reload_d = reload_q;
        cnt_d    = cnt_q;
        window_d = window_q;
        warn_d   = warn_q;
        stat_d   = stat_q;
        ien_d    = ien_q;
        pre_d    = pre_q;
        wclk_d   = wclk_s;
        armed_d  = armed_q;
        rreq_d   = 1'b0;
        rdata_d  = rdata_q;
        warned_d = warned_q;
        // prescaler counts watchdog clock edges while running
        if (run && wclk_s && !wclk_q) begin
            pre_d = pre_q + 2'h1;
        end
        if (tick && cnt_q != '0) begin
            cnt_d = cnt_q - 24'h000001;
        end
        // warning point reached: flag and open reload protection
        if (tick && cnt_q[23:10] == '0 && cnt_q[9:0] == warn_q) begin
            stat_d[WWD_ST_WARN] = 1'b1;
            warned_d            = 1'b1;
        end
        // feed key tracking
        if (psel && penable) begin
            armed_d = wr_stb && paddr == WWD_OFS_FEED && !armed_q
                    && pwdata[7:0] == WWD_KEY_FIRST;
        end
        if (wr_stb) begin
            unique case (paddr)
                WWD_OFS_CTRL: begin
                    // enable is set-only once written
                    ctrl_d = pwdata[WWD_CTL_BITS-1:0]
                           | {{(WWD_CTL_BITS-1){1'b0}}, ctrl_q[WWD_CTL_ENABLE]};
                    if (ctrl_q[WWD_CTL_ENABLE]) begin
                        ctrl_d[WWD_CTL_RESET]   = ctrl_q[WWD_CTL_RESET] | pwdata[WWD_CTL_RESET];
                        ctrl_d[WWD_CTL_PROTECT] = ctrl_q[WWD_CTL_PROTECT]
                                                | pwdata[WWD_CTL_PROTECT];
                    end
                end
                WWD_OFS_RELOAD: begin
                    // short values are clamped rather than refused
                    if (!ctrl_q[WWD_CTL_PROTECT] || warned_q) begin
                        reload_d = (pwdata[23:0] < WWD_CNT_MIN) ? WWD_CNT_MIN
                                                                 : pwdata[23:0];
                    end
                end
                WWD_OFS_WARN:    warn_d   = pwdata[9:0];
                WWD_OFS_WINDOW:  window_d = pwdata[23:0];
                WWD_OFS_IRQ_EN:  ien_d    = pwdata[WWD_ST_BITS-1:0];
                WWD_OFS_IRQ_CLR: stat_d   = stat_d & ~pwdata[WWD_ST_BITS-1:0];
                default: ;
            endcase
        end
        // a valid feed reloads the counter; feeds also accepted while disabled
        if (feed_ok && !feed_bad) begin
            cnt_d    = reload_d;
            pre_d    = 2'h0;
            warned_d = 1'b0;
        end
        // hardware sets win over a same-cycle clear
        if (expire)   stat_d[WWD_ST_TIMEOUT] = 1'b1;
        if (feed_bad) stat_d[WWD_ST_BADFEED] = 1'b1;
        if (tick && cnt_q[23:10] == '0 && cnt_q[9:0] == warn_q) begin
            stat_d[WWD_ST_WARN] = 1'b1;
        end
        // one request per event; the request cycle itself starts no second one
        if (event_fire && ctrl_q[WWD_CTL_RESET] && !rreq_q) begin
            stat_d[WWD_ST_WDRESET] = 1'b1;
            rreq_d                 = 1'b1;
        end
        // registered read data
        if (rd_stb) begin
            unique case (paddr)
                WWD_OFS_CTRL:   rdata_d = {27'h0, ctrl_q};
                WWD_OFS_RELOAD: rdata_d = {8'h00, reload_q};
                WWD_OFS_COUNT:  rdata_d = {8'h00, cnt_q};
                WWD_OFS_WARN:   rdata_d = {22'h0, warn_q};
                WWD_OFS_WINDOW: rdata_d = {8'h00, window_q};
                WWD_OFS_STATUS: rdata_d = {28'h0, stat_q};
                WWD_OFS_IRQ_EN: rdata_d = {28'h0, ien_q};
                default:        rdata_d = 32'h0;
            endcase
        end
    end

    // all state but status and rreq_q; a watchdog reset request clears it like rst
    always_ff @(posedge core_clk) begin
        if (rst || rreq_q) begin
            ctrl_q   <= '0;
            reload_q <= WWD_RELOAD_RST;
            cnt_q    <= WWD_RELOAD_RST;
            window_q <= WWD_WINDOW_RST;
            warn_q   <= WWD_WARN_RST;
            ien_q    <= '0;
            pre_q    <= 2'h0;
            // follow the pin so that leaving reset makes no false edge
            wclk_q   <= wclk_s;
            armed_q  <= 1'b0;
            rdata_q  <= 32'h0;
            warned_q <= 1'b0;
        end else begin
            ctrl_q   <= ctrl_d;
            reload_q <= reload_d;
            cnt_q    <= cnt_d;
            window_q <= window_d;
            warn_q   <= warn_d;
            ien_q    <= ien_d;
            pre_q    <= pre_d;
            wclk_q   <= wclk_d;
            armed_q  <= armed_d;
            rdata_q  <= rdata_d;
            warned_q <= warned_d;
        end
    end

    // status survives a watchdog reset so software sees its cause
    always_ff @(posedge core_clk) begin
        if (rst) begin
            stat_q <= '0;
            rreq_q <= 1'b0;
        end else begin
            stat_q <= stat_d;
            rreq_q <= rreq_d;
        end
    end

    // interrupt mode when reset select is clear
    // the level stays up until software clears the status bit
    assign irq = |(stat_q & ien_q);
    assign wdt_reset_req = rreq_q;

    // two-step feed: first key, then the second key on the next access
    sequence seq_first_key;
        wr_stb && paddr == WWD_OFS_FEED && !armed_q
        && pwdata[7:0] == WWD_KEY_FIRST && !rreq_q;
    endsequence
    sequence seq_second_key;
        wr_stb && paddr == WWD_OFS_FEED && armed_q
        && pwdata[7:0] == WWD_KEY_SECOND && !rreq_q;
    endsequence
    // watchdog event in reset mode, then a request that lasts one cycle
    sequence seq_reset_event;
        event_fire && ctrl_q[WWD_CTL_RESET] && !rreq_q;
    endsequence
    sequence seq_reset_pulse;
        wdt_reset_req ##1 !wdt_reset_req;
    endsequence

    // enable and reset request checks
    chk_enable_sticky: assert property (@(posedge core_clk) disable iff (rst)
        $past(ctrl_q[WWD_CTL_ENABLE]) && !$past(rreq_q) |-> ctrl_q[WWD_CTL_ENABLE])
        else $error("enable cleared by software");
    chk_expire_reset: assert property (@(posedge core_clk) disable iff (rst)
        expire && ctrl_q[WWD_CTL_RESET] && !rreq_q |=> wdt_reset_req)
        else $error("expiry without reset");
    chk_reset_pulse: assert property (@(posedge core_clk) disable iff (rst)
        seq_reset_event |=> seq_reset_pulse)
        else $error("reset request not one cycle");
    chk_idle_no_reset: assert property (@(posedge core_clk) disable iff (rst)
        !ctrl_q[WWD_CTL_ENABLE] |-> !wdt_reset_req)
        else $error("reset request while disabled");
    chk_irq_no_reset: assert property (@(posedge core_clk) disable iff (rst)
        event_fire && !ctrl_q[WWD_CTL_RESET] && !rreq_q |=> !wdt_reset_req)
        else $error("reset request in interrupt mode");
    chk_reset_flag: assert property (@(posedge core_clk) disable iff (rst)
        wdt_reset_req |-> stat_q[WWD_ST_WDRESET])
        else $error("reset flag missing");

    // feed sequence checks
    chk_feed_arm: assert property (@(posedge core_clk) disable iff (rst)
        seq_first_key |=> armed_q)
        else $error("first key not remembered");
    chk_feed_load: assert property (@(posedge core_clk) disable iff (rst)
        seq_second_key ##0 !feed_bad |=> cnt_q == $past(reload_d))
        else $error("valid feed did not reload");
    chk_bad_feed: assert property (@(posedge core_clk) disable iff (rst)
        feed_bad |=> stat_q[WWD_ST_BADFEED])
        else $error("bad feed not flagged");
    chk_window_fault: assert property (@(posedge core_clk) disable iff (rst)
        feed_ok && ctrl_q[WWD_CTL_ENABLE] && cnt_q > window_q |-> feed_bad)
        else $error("early feed accepted");
    chk_window_ok: assert property (@(posedge core_clk) disable iff (rst)
        seq_second_key ##0 (cnt_q <= window_q) |-> !feed_bad)
        else $error("feed inside window refused");

    // counter, power state and reload checks
    chk_reload_min: assert property (@(posedge core_clk) disable iff (rst)
        reload_q >= WWD_CNT_MIN)
        else $error("reload below minimum");
    chk_warn_flag: assert property (@(posedge core_clk) disable iff (rst)
        tick && cnt_q == {14'h0, warn_q} |=> stat_q[WWD_ST_WARN])
        else $error("warning point not flagged");
    chk_sleep_hold: assert property (@(posedge core_clk) disable iff (rst)
        sleep_s && !ctrl_q[WWD_CTL_SLEEP] && !feed_ok && !rreq_q |=> $stable(cnt_q))
        else $error("counter moved in deep sleep");
    chk_halt_hold: assert property (@(posedge core_clk) disable iff (rst)
        halt_s && ctrl_q[WWD_CTL_DEBUG] && !feed_ok && !rreq_q |=> $stable(cnt_q))
        else $error("counter moved in debug halt");
    chk_protect: assert property (@(posedge core_clk) disable iff (rst)
        wr_stb && paddr == WWD_OFS_RELOAD && ctrl_q[WWD_CTL_PROTECT] && !warned_q
        && !rreq_q |=> $stable(reload_q))
        else $error("protected reload changed");
endmodule
`default_nettype wire

// ===== windowed_watchdog_timer_tb.sv
/*
 * windowed_watchdog_timer_tb: self-checking bench for wwd_top over apb.
 * assumes: wwd_pkg and wwd_top compiled first; 20 MHz core clock, pins driven here.
 */
`timescale 1ns/1ps
`default_nettype none
module windowed_watchdog_timer_tb
    import wwd_pkg::*;
();
    logic        core_clk       = 1'b0;
    logic        rst            = 1'b1;
    logic        psel           = 1'b0;
    logic        penable        = 1'b0;
    logic        pwrite         = 1'b0;
    logic [7:0]  paddr          = 8'h00;
    logic [31:0] pwdata         = 32'h0;
    logic        watchdog_clock = 1'b0;
    logic        deep_sleep     = 1'b0;
    logic        debug_halt     = 1'b0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        wdt_reset_req;
    logic        irq;
    logic        last_req       = 1'b0;
    int          error_cnt      = 0;
    int          samples_checked = 0;
    int          pulses         = 0;
    int          long_pulses    = 0;
    int          wd_div         = 0;

    // 50 ns period
    always #25 core_clk = ~core_clk;

    // slow pin clock of 800 ns; also counts reset pulses and over-long ones
    always @(posedge core_clk) begin
        wd_div <= (wd_div == 7) ? 0 : wd_div + 1;
        if (wd_div == 7) watchdog_clock <= ~watchdog_clock;
        last_req <= wdt_reset_req;
        if (wdt_reset_req === 1'b1) pulses <= pulses + 1;
        if (wdt_reset_req === 1'b1 && last_req === 1'b1) long_pulses <= long_pulses + 1;
    end

    wwd_top DUT (
        .core_clk       (core_clk),
        .rst            (rst),
        .psel           (psel),
        .penable        (penable),
        .pwrite         (pwrite),
        .paddr          (paddr),
        .pwdata         (pwdata),
        .prdata         (prdata),
        .pready         (pready),
        .pslverr        (pslverr),
        .watchdog_clock (watchdog_clock),
        .deep_sleep     (deep_sleep),
        .debug_halt     (debug_halt),
        .wdt_reset_req  (wdt_reset_req),
        .irq            (irq)
    );

    task automatic print_verdict;
        $display("checks=%0d errors=%0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    function automatic logic in_rng(input logic [31:0] v, input logic [31:0] lo,
                                    input logic [31:0] hi);
        return (v >= lo) && (v <= hi);
    endfunction

    // one apb transfer; response taken at the edge where pready is high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic err);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        // no cycle count assumed; the wait ends when pready is high, with no limit but the hang guard
        do begin
            @(posedge core_clk);
        end while (pready !== 1'b1);
        err = pslverr;
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge core_clk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] x;
        logic        e;
        apb(1'b1, a, d, x, e);
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        logic e;
        apb(1'b0, a, 32'h0, d, e);
    endtask

    task automatic feed;
        wr(WWD_OFS_FEED, {24'h0, WWD_KEY_FIRST});
        wr(WWD_OFS_FEED, {24'h0, WWD_KEY_SECOND});
    endtask

    task automatic do_reset;
        rst <= 1'b1;
        repeat (12) @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk);
    endtask

    // extra core cycles cover the two-flop pin synchroniser
    task automatic wait_wd(input int n);
        repeat (n) @(posedge watchdog_clock);
        repeat (4) @(posedge core_clk);
    endtask

    task automatic wait_irq(input int lim);
        int n;
        n = 0;
        while (irq !== 1'b1 && n < lim) begin
            @(posedge core_clk);
            n++;
        end
    endtask

    task automatic t_reset_values;
        logic [31:0] d;
        logic        e;
        rd(WWD_OFS_CTRL, d);
        check_val(d, 32'h0);
        rd(WWD_OFS_RELOAD, d);
        check_val(d, {8'h00, WWD_RELOAD_RST});
        rd(WWD_OFS_WINDOW, d);
        check_val(d, {8'h00, WWD_WINDOW_RST});
        rd(WWD_OFS_STATUS, d);
        check_val(d, 32'h0);
        apb(1'b0, 8'h40, 32'h0, d, e);
        check_val({31'h0, e}, 32'h1);
        check_val({30'h0, irq, wdt_reset_req}, 32'h0);
    endtask

    // interrupt mode: clamp, prescale, sticky enable, warning, expiry
    task automatic t_irq_mode;
        logic [31:0] d;
        wr(WWD_OFS_IRQ_EN, 32'hF);
        wr(WWD_OFS_WARN, 32'hF0);
        wr(WWD_OFS_CTRL, 32'h1);
        wr(WWD_OFS_RELOAD, 32'h10);
        feed;
        rd(WWD_OFS_COUNT, d);
        check_val({31'h0, in_rng(d, 32'hFF, 32'h100)}, 32'h1);
        wait_wd(40);
        rd(WWD_OFS_COUNT, d);
        check_val({31'h0, in_rng(d, 32'hF4, 32'hF7)}, 32'h1);
        wr(WWD_OFS_CTRL, 32'h0);
        rd(WWD_OFS_CTRL, d);
        check_val(d & 32'h1, 32'h1);
        wait_irq(3000);
        rd(WWD_OFS_STATUS, d);
        check_val(d & 32'h3, 32'h2);
        rd(WWD_OFS_COUNT, d);
        check_val({31'h0, in_rng(d, 32'hEF, 32'hF0)}, 32'h1);
        wr(WWD_OFS_IRQ_CLR, 32'h2);
        check_val({31'h0, irq}, 32'h0);
        wait_irq(20000);
        rd(WWD_OFS_STATUS, d);
        check_val(d & 32'h1, 32'h1);
        check_val(pulses, 32'h0);
    endtask

    // early feed against the window, then a broken key pair
    task automatic t_feed_faults;
        logic [31:0] d;
        do_reset;
        wr(WWD_OFS_WINDOW, 32'h80);
        wr(WWD_OFS_RELOAD, 32'h100);
        feed;
        wr(WWD_OFS_IRQ_EN, 32'hF);
        wr(WWD_OFS_CTRL, 32'h1);
        rd(WWD_OFS_STATUS, d);
        check_val(d & 32'h4, 32'h0);
        feed;
        rd(WWD_OFS_STATUS, d);
        check_val(d & 32'h4, 32'h4);
        check_val({31'h0, irq}, 32'h1);
        do_reset;
        wr(WWD_OFS_IRQ_EN, 32'hF);
        wr(WWD_OFS_CTRL, 32'h1);
        feed;
        rd(WWD_OFS_STATUS, d);
        check_val(d & 32'h4, 32'h0);
        wr(WWD_OFS_FEED, {24'h0, WWD_KEY_FIRST});
        rd(WWD_OFS_COUNT, d);
        wr(WWD_OFS_FEED, {24'h0, WWD_KEY_SECOND});
        rd(WWD_OFS_STATUS, d);
        check_val(d & 32'h4, 32'h4);
    endtask

    // reset mode: protected reload, expiry pulse, flag, instant fault reset
    task automatic t_reset_mode;
        logic [31:0] d;
        int          n;
        int          p0;
        do_reset;
        wr(WWD_OFS_RELOAD, 32'h100);
        wr(WWD_OFS_CTRL, 32'h7);
        feed;
        wr(WWD_OFS_RELOAD, 32'h200);
        rd(WWD_OFS_RELOAD, d);
        check_val(d, 32'h100);
        p0 = pulses;
        n = 0;
        while (pulses == p0 && n < 20000) begin
            @(posedge core_clk);
            n++;
        end
        check_val({31'h0, in_rng(n, 16000, 16700)}, 32'h1);
        check_val(long_pulses, 32'h0);
        rd(WWD_OFS_STATUS, d);
        check_val(d & 32'h8, 32'h8);
        rd(WWD_OFS_CTRL, d);
        check_val(d & 32'h1, 32'h0);
        wr(WWD_OFS_CTRL, 32'h3);
        feed;
        p0 = pulses;
        wr(WWD_OFS_FEED, {24'h0, WWD_KEY_FIRST});
        wr(WWD_OFS_FEED, 32'h12);
        repeat (4) @(posedge core_clk);
        check_val(pulses - p0, 32'h1);
    endtask

    // counting under deep sleep, with and without run-in-sleep, and debug freeze
    task automatic t_sleep_debug;
        logic [31:0] c1;
        logic [31:0] c2;
        wr(WWD_OFS_CTRL, 32'h1);
        feed;
        deep_sleep <= 1'b1;
        wait_wd(2);
        rd(WWD_OFS_COUNT, c1);
        wait_wd(40);
        rd(WWD_OFS_COUNT, c2);
        check_val(c2, c1);
        wr(WWD_OFS_CTRL, 32'h9);
        rd(WWD_OFS_COUNT, c1);
        wait_wd(40);
        rd(WWD_OFS_COUNT, c2);
        check_val({31'h0, in_rng(c1 - c2, 32'd9, 32'd11)}, 32'h1);
        deep_sleep <= 1'b0;
        wr(WWD_OFS_CTRL, 32'h19);
        debug_halt <= 1'b1;
        wait_wd(2);
        rd(WWD_OFS_COUNT, c1);
        wait_wd(40);
        rd(WWD_OFS_COUNT, c2);
        check_val(c2, c1);
        debug_halt <= 1'b0;
    endtask

    // main sequence
    initial begin
        repeat (12) @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk);
        t_reset_values;
        t_irq_mode;
        t_feed_faults;
        t_reset_mode;
        t_sleep_debug;
        print_verdict;
    end

    // hang guard, roughly twice the expected run
    initial begin
        #3000000;
        error_cnt++;
        print_verdict;
    end
endmodule
`default_nettype wire
